/* File: hdl/hlp_pkg.sv */
package hlp_pkg;

   // log identifiers and namespace selector
   localparam logic [7:0]  LID_ERR     = 8'h01;
   localparam logic [7:0]  LID_HLTH    = 8'h02;
   localparam logic [31:0] NSID_GLOBAL = 32'hFFFF_FFFF;

   // error entry layout, in dwords of the 64-byte entry
   localparam int          ENTRY_BYTES = 64;
   localparam logic [6:0]  ENTRY_DW    = 7'(ENTRY_BYTES / 4);
   localparam logic [6:0]  DW_CMD      = 7'h02;
   localparam logic [6:0]  DW_LBA_LO   = 7'h04;
   localparam logic [6:0]  DW_LBA_HI   = 7'h05;
   localparam logic [6:0]  DW_NSID     = 7'h06;
   localparam logic [6:0]  DW_VS       = 7'h07;
   localparam logic [6:0]  DW_CSI_LO   = 7'h08;
   localparam logic [6:0]  DW_CSI_HI   = 7'h09;
   localparam logic [15:0] CMD_NONE    = 16'hFFFF;
   localparam logic [7:0]  VS_NONE     = 8'h00;
   localparam int          VS_MSB      = 7;

   // health page dwords
   localparam logic [6:0]  DW_H0       = 7'h00;
   localparam logic [6:0]  DW_H1       = 7'h01;

   // critical warning bits
   localparam int          W_SPARE     = 0;
   localparam int          W_TEMP      = 1;
   localparam int          W_REL       = 2;
   localparam int          W_RO        = 3;
   localparam int          W_VMB       = 4;
   localparam int          W_N         = 5;

   // register offsets
   localparam logic [7:0]  R_CFG       = 8'h00;
   localparam logic [7:0]  R_SPARE_THR = 8'h04;
   localparam logic [7:0]  R_TEMP_THR  = 8'h08;
   localparam logic [7:0]  R_ERR_CMD   = 8'h0C;
   localparam logic [7:0]  R_ERR_FLG   = 8'h10;
   localparam logic [7:0]  R_LBA_LO    = 8'h14;
   localparam logic [7:0]  R_LBA_HI    = 8'h18;
   localparam logic [7:0]  R_ERR_NSID  = 8'h1C;
   localparam logic [7:0]  R_CSI_LO    = 8'h20;
   localparam logic [7:0]  R_CSI_HI    = 8'h24;
   localparam logic [7:0]  R_WARN      = 8'h28;

   // field positions
   localparam int          CFG_NS_EN   = 0;
   localparam int          CFG_AEN_LSB = 8;
   localparam int          FLG_CMD_REL = 0;
   localparam int          FLG_CSI_VAL = 1;
   localparam int          FLG_VS_LSB  = 8;

   typedef enum logic [1:0] {
      ST_OK        = 2'h0,
      ST_BAD_FIELD = 2'h1,
      ST_BAD_LOG   = 2'h2
   } hlp_status_t;

   typedef struct packed {
      logic [7:0]  lid;
      logic [31:0] nsid;
      logic [6:0]  dw;
   } hlp_req_t;

   typedef struct packed {
      hlp_status_t status;
      logic [31:0] data;
   } hlp_rsp_t;

   typedef struct packed {
      logic [15:0] temp;
      logic [7:0]  spare;
      logic [7:0]  pct_used;
      logic        degraded;
      logic        read_only;
      logic        vmb_fail;
   } hlp_hin_t;

endpackage

/* File: hdl/hlp_log_pages.sv */
`timescale 1ns/1ps
// Functional notes
// [RULE_01] error page id 01h, health page 02h
// [RULE_02] error page made of 64-byte entries
// [RULE_03] no related command: identifiers all ones
// [RULE_04] first failing block address, bytes 23:16
// [RULE_05] namespace of error, bytes 27:24
// [RULE_06] byte 28 vendor page id, 80h-FFh or 0
// [RULE_07] bytes 39:32 only when command defines them
// [RULE_08] reserved entry bytes read as zero
// [RULE_09] health contents persist, not reset here; RESET here clears the spare threshold byte (spare_thr_q) to 00h
// [RULE_10] all-ones namespace selects global health page
// [RULE_11] other namespace rejected unless per-namespace enabled
// [RULE_12] per-namespace page equals global page
// [RULE_13] byte 0 holds critical warning bitmask
// [RULE_14] warnings reflect present conditions, not latched
// [RULE_15] bit 0: spare below threshold
// [RULE_16] bit 1: temperature outside thresholds
// [RULE_17] bits 2-4: reliability, read-only, backup failed
// [RULE_18] host-selected warnings raise event notification
module hlp_log_pages
   import hlp_pkg::*;
(
   // clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        RESET,
   // register port
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic [31:0]      REG_RDATA,
   // log page request and answer
   input  wire logic        LP_REQ,
   input  wire hlp_req_t    LP_REQ_INFO,
   output logic             LP_ACK,
   output hlp_rsp_t         LP_RSP,
   // live health conditions
   input  wire hlp_hin_t    HLTH_IN,
   // event notification
   output logic             AEN_PULSE,
   output logic [W_N-1:0]   AEN_WARN
);

   logic              ns_en_q;
   logic [W_N-1:0]    aen_mask_q;
   logic [7:0]        spare_thr_q;
   logic [15:0]       temp_over_q;
   logic [15:0]       temp_under_q;
   logic [15:0]       sqid_q;
   logic [15:0]       cid_q;
   logic              cmd_rel_q;
   logic              csi_val_q;
   logic [7:0]        vs_lid_q;
   logic [31:0]       lba_lo_q;
   logic [31:0]       lba_hi_q;
   logic [31:0]       err_nsid_q;
   logic [31:0]       csi_lo_q;
   logic [31:0]       csi_hi_q;
   logic [W_N-1:0]    warn;
   logic [W_N-1:0]    warn_prev_q;
   logic [W_N-1:0]    aen_rise;
   logic [31:0]       err_dw;
   logic [31:0]       hl_dw;
   logic [31:0]       rd_d;
   hlp_rsp_t          rsp_d;
   logic [7:0]        vs_wr;

   // live warning bitmask, no latching
   always_comb begin
      warn         = '0;
      warn[W_SPARE] = HLTH_IN.spare < spare_thr_q;                      // [RULE_15] [RULE_14]
      warn[W_TEMP]  = (HLTH_IN.temp > temp_over_q) ||
                      (HLTH_IN.temp < temp_under_q);                    // [RULE_16]
      warn[W_REL]   = HLTH_IN.degraded;                                 // [RULE_17]
      warn[W_RO]    = HLTH_IN.read_only;                                // [RULE_17]
      warn[W_VMB]   = HLTH_IN.vmb_fail;                                 // [RULE_17]
   end

   // vendor page id outside 80h-FFh stored as none
   assign vs_wr = REG_WDATA[FLG_VS_LSB+VS_MSB] ?
                  REG_WDATA[FLG_VS_LSB +: 8] : VS_NONE;                 // [RULE_06]

   // configuration registers
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         ns_en_q      <= 1'b0;
         aen_mask_q   <= '0;
         spare_thr_q  <= 8'h00;
         temp_over_q  <= 16'hFFFF;
         temp_under_q <= 16'h0000;
      end else if (REG_WR) begin
         if (REG_ADDR == R_CFG) begin
            ns_en_q    <= REG_WDATA[CFG_NS_EN];
            aen_mask_q <= REG_WDATA[CFG_AEN_LSB +: W_N];
         end
         if (REG_ADDR == R_SPARE_THR) begin
            spare_thr_q <= REG_WDATA[7:0];
         end
         if (REG_ADDR == R_TEMP_THR) begin
            temp_over_q  <= REG_WDATA[15:0];
            temp_under_q <= REG_WDATA[31:16];
         end
      end
   end

   // current error entry fields
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         sqid_q     <= 16'h0000;
         cid_q      <= 16'h0000;
         cmd_rel_q  <= 1'b0;
         csi_val_q  <= 1'b0;
         vs_lid_q   <= VS_NONE;
         lba_lo_q   <= 32'h0000_0000;
         lba_hi_q   <= 32'h0000_0000;
         err_nsid_q <= 32'h0000_0000;
         csi_lo_q   <= 32'h0000_0000;
         csi_hi_q   <= 32'h0000_0000;
      end else if (REG_WR) begin
         if (REG_ADDR == R_ERR_CMD) begin
            sqid_q <= REG_WDATA[15:0];
            cid_q  <= REG_WDATA[31:16];
         end
         if (REG_ADDR == R_ERR_FLG) begin
            cmd_rel_q <= REG_WDATA[FLG_CMD_REL];
            csi_val_q <= REG_WDATA[FLG_CSI_VAL];
            vs_lid_q  <= vs_wr;                                         // [RULE_06]
         end
         if (REG_ADDR == R_LBA_LO) begin
            lba_lo_q <= REG_WDATA;
         end
         if (REG_ADDR == R_LBA_HI) begin
            lba_hi_q <= REG_WDATA;
         end
         if (REG_ADDR == R_ERR_NSID) begin
            err_nsid_q <= REG_WDATA;
         end
         if (REG_ADDR == R_CSI_LO) begin
            csi_lo_q <= REG_WDATA;
         end
         if (REG_ADDR == R_CSI_HI) begin
            csi_hi_q <= REG_WDATA;
         end
      end
   end

   // register read mux, unmapped reads zero
   always_comb begin
      rd_d = 32'h0000_0000;
      unique case (REG_ADDR)
         R_CFG:       rd_d = {19'h0_0000, aen_mask_q, 7'h00, ns_en_q};
         R_SPARE_THR: rd_d = {24'h00_0000, spare_thr_q};
         R_TEMP_THR:  rd_d = {temp_under_q, temp_over_q};
         R_ERR_CMD:   rd_d = {cid_q, sqid_q};
         R_ERR_FLG:   rd_d = {16'h0000, vs_lid_q, 6'h00, csi_val_q, cmd_rel_q};
         R_LBA_LO:    rd_d = lba_lo_q;
         R_LBA_HI:    rd_d = lba_hi_q;
         R_ERR_NSID:  rd_d = err_nsid_q;
         R_CSI_LO:    rd_d = csi_lo_q;
         R_CSI_HI:    rd_d = csi_hi_q;
         R_WARN:      rd_d = {27'h000_0000, warn};                      // [RULE_14]
         default:     rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         REG_RDATA <= 32'h0000_0000;
      end else begin
         REG_RDATA <= REG_RD ? rd_d : 32'h0000_0000;
      end
   end

   // error entry dword
   always_comb begin
      err_dw = 32'h0000_0000;                                           // [RULE_08] [RULE_02]
      if (LP_REQ_INFO.dw < ENTRY_DW) begin
         unique case (LP_REQ_INFO.dw)
            DW_CMD:    err_dw = cmd_rel_q ? {cid_q, sqid_q}
                                          : {CMD_NONE, CMD_NONE};       // [RULE_03]
            DW_LBA_LO: err_dw = lba_lo_q;                               // [RULE_04]
            DW_LBA_HI: err_dw = lba_hi_q;                               // [RULE_04]
            DW_NSID:   err_dw = err_nsid_q;                             // [RULE_05]
            DW_VS:     err_dw = {24'h00_0000, vs_lid_q};                // [RULE_06] [RULE_08]
            DW_CSI_LO: err_dw = csi_val_q ? csi_lo_q : 32'h0000_0000;   // [RULE_07]
            DW_CSI_HI: err_dw = csi_val_q ? csi_hi_q : 32'h0000_0000;   // [RULE_07]
            default:   err_dw = 32'h0000_0000;                          // [RULE_08]
         endcase
      end
   end

   // health dword from live inputs and spare_thr_q; lifetime values kept upstream
   always_comb begin
      hl_dw = 32'h0000_0000;
      unique case (LP_REQ_INFO.dw)
         DW_H0:   hl_dw = {HLTH_IN.spare, HLTH_IN.temp, 3'h0, warn};    // [RULE_13] [RULE_09]
         DW_H1:   hl_dw = {16'h0000, HLTH_IN.pct_used, spare_thr_q};    // [RULE_09]
         default: hl_dw = 32'h0000_0000;
      endcase
   end

   // page select and namespace check
   always_comb begin
      rsp_d.status = ST_BAD_LOG;
      rsp_d.data   = 32'h0000_0000;
      if (LP_REQ_INFO.lid == LID_ERR) begin                             // [RULE_01]
         rsp_d.status = ST_OK;
         rsp_d.data   = err_dw;
      end else if (LP_REQ_INFO.lid == LID_HLTH) begin                   // [RULE_01]
         if (LP_REQ_INFO.nsid != NSID_GLOBAL && !ns_en_q) begin         // [RULE_10]
            rsp_d.status = ST_BAD_FIELD;                                // [RULE_11]
         end else begin
            rsp_d.status = ST_OK;
            rsp_d.data   = hl_dw;                                       // [RULE_12]
         end
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         LP_ACK <= 1'b0;
         LP_RSP <= '{status: ST_OK, data: 32'h0000_0000};
      end else begin
         LP_ACK <= LP_REQ;
         if (LP_REQ) begin
            LP_RSP <= rsp_d;
         end
      end
   end

   // event on newly asserted, host-enabled warning
   assign aen_rise = warn & ~warn_prev_q & aen_mask_q;                  // [RULE_18]

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         warn_prev_q <= '0;
         AEN_PULSE   <= 1'b0;
         AEN_WARN    <= '0;
      end else begin
         warn_prev_q <= warn;
         AEN_PULSE   <= |aen_rise;                                      // [RULE_18]
         if (|aen_rise) begin
            AEN_WARN <= aen_rise;
         end
      end
   end

   // checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);

   sequence s_req(logic [7:0] l, logic [6:0] d);
      LP_REQ && LP_REQ_INFO.lid == l && LP_REQ_INFO.dw == d;
   endsequence

   sequence s_hreq;
      LP_REQ && LP_REQ_INFO.lid == LID_HLTH;
   endsequence

   a_bad_log: assert property (                                         // [RULE_01]
      LP_REQ && LP_REQ_INFO.lid != LID_ERR && LP_REQ_INFO.lid != LID_HLTH
      |=> LP_ACK && LP_RSP.status == ST_BAD_LOG)
      else $error("unknown log id not refused");

   a_past_entry: assert property (                                      // [RULE_02]
      LP_REQ && LP_REQ_INFO.lid == LID_ERR && LP_REQ_INFO.dw >= ENTRY_DW
      |=> LP_RSP.data == 32'h0000_0000)
      else $error("data beyond entry not zero");

   a_cmd_none: assert property (                                        // [RULE_03]
      s_req(LID_ERR, DW_CMD) ##0 !cmd_rel_q |=> LP_RSP.data == 32'hFFFF_FFFF)
      else $error("unrelated entry ids not all ones");

   a_lba_place: assert property (                                       // [RULE_04]
      s_req(LID_ERR, DW_LBA_LO) |=> LP_RSP.data == $past(lba_lo_q))
      else $error("block address misplaced");

   a_nsid_place: assert property (                                      // [RULE_05]
      s_req(LID_ERR, DW_NSID) |=> LP_RSP.data == $past(err_nsid_q))
      else $error("entry namespace misplaced");

   a_vs_range: assert property (                                        // [RULE_06]
      s_req(LID_ERR, DW_VS) |=> LP_RSP.data[31:8] == 24'h00_0000 &&
      (LP_RSP.data[7:0] == VS_NONE || LP_RSP.data[VS_MSB]))
      else $error("vendor page id out of range");

   a_csi_gate: assert property (                                        // [RULE_07]
      s_req(LID_ERR, DW_CSI_LO) ##0 !csi_val_q |=> LP_RSP.data == 32'h0000_0000)
      else $error("command info returned when undefined");

   a_ns_reject: assert property (                                       // [RULE_11]
      s_hreq ##0 (LP_REQ_INFO.nsid != NSID_GLOBAL && !ns_en_q)
      |=> LP_RSP.status == ST_BAD_FIELD)
      else $error("namespace request not refused");

   a_ns_same: assert property (                                         // [RULE_12]
      s_hreq ##0 ns_en_q |=> LP_RSP.status == ST_OK &&
      LP_RSP.data == $past(hl_dw))
      else $error("namespace page differs from global");

   a_warn_live: assert property (                                       // [RULE_15]
      s_req(LID_HLTH, DW_H0) ##0 LP_REQ_INFO.nsid == NSID_GLOBAL
      |=> LP_RSP.data[W_SPARE] == $past(HLTH_IN.spare < spare_thr_q))
      else $error("spare warning not current");

   a_aen_fire: assert property (                                        // [RULE_18]
      (|(warn & ~warn_prev_q & aen_mask_q)) |=> AEN_PULSE &&
      AEN_WARN == $past(warn & ~warn_prev_q & aen_mask_q))
      else $error("event not raised");

   a_aen_mask: assert property (                                        // [RULE_18]
      AEN_PULSE |-> (AEN_WARN & ~$past(aen_mask_q)) == '0)
      else $error("masked warning raised event");

endmodule

/* File: dv/hlp_host_model.sv */
`timescale 1ns/1ps
module hlp_host_model
   import hlp_pkg::*;
(
   // clock
   input  wire logic     clk,
   // request side
   output logic          req,
   output hlp_req_t      info,
   // answer side
   input  wire logic     ack,
   input  wire hlp_rsp_t rsp
);
   initial begin
      req = 1'b0;
      info = '0;
   end

   // one dword per request, answer taken the cycle after
   task automatic fetch(input logic [7:0] l, input logic [31:0] n, input logic [6:0] d,
                        output logic a, output hlp_rsp_t r);
      @(posedge clk);
      req <= 1'b1;
      info <= '{l, n, d};
      @(posedge clk);
      req <= 1'b0;
      info <= ~info; // released lines do not keep the last value
      #1;
      a = ack;
      r = rsp;
   endtask
endmodule

/* File: dv/hlp_log_pages_tb_top.sv */
`timescale 1ns/1ps
module hlp_log_pages_tb_top
   import hlp_pkg::*;
;
   logic        clk, rst, wr, rd, lp_req, lp_ack, aen_pulse, a;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, seed, x;
   logic [4:0]  aen_warn;
   hlp_req_t    info;
   hlp_rsp_t    rsp, r;
   hlp_hin_t    hin;
   logic [31:0] m [64];
   logic [15:0] tt [7] = '{16'h015E, 16'h015E, 16'h015F, 16'h010D, 16'h010E, 16'h012C, 16'h012C};
   logic [7:0]  sp [7] = '{8'h13, 8'h14, 8'h14, 8'h14, 8'h14, 8'h64, 8'h64};
   logic [2:0]  fl [7] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h2, 3'h1};
   logic [7:0]  bad [4] = '{8'h00, 8'h03, 8'h7F, 8'hFF};
   int          miscompares, compares, i, j, k;

   hlp_log_pages DUT (
      .REF_CLK     (clk),
      .RESET       (rst),
      .REG_ADDR    (addr),
      .REG_WDATA   (wdata),
      .REG_WR      (wr),
      .REG_RD      (rd),
      .REG_RDATA   (rdata),
      .LP_REQ      (lp_req),
      .LP_REQ_INFO (info),
      .LP_ACK      (lp_ack),
      .LP_RSP      (rsp),
      .HLTH_IN     (hin),
      .AEN_PULSE   (aen_pulse),
      .AEN_WARN    (aen_warn)
   );

   hlp_host_model host (
      .clk  (clk),
      .req  (lp_req),
      .info (info),
      .ack  (lp_ack),
      .rsp  (rsp)
   );

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic hlp_hin_t mk(input logic [15:0] t, input logic [7:0] s,
                                   input logic [2:0] f);
      return '{t, s, seed[7:0], f[2], f[1], f[0]};
   endfunction

   function automatic logic [4:0] exp_warn();
      return {hin.vmb_fail, hin.read_only, hin.degraded,
              (hin.temp > m[2][15:0] || hin.temp < m[2][31:16]), (hin.spare < m[1][7:0])};
   endfunction

   function automatic logic [31:0] h0();
      return {hin.spare, hin.temp, 3'b000, exp_warn()};
   endfunction

   function automatic logic [31:0] h1();
      return {16'h0000, hin.pct_used, m[1][7:0]};
   endfunction

   function automatic logic [31:0] exp_err(input int d);
      case (d)
         2: return m[4][FLG_CMD_REL] ? m[3] : 32'hFFFF_FFFF;
         4: return m[5];
         5: return m[6];
         6: return m[7];
         7: return {24'h00_0000, m[4][15] ? m[4][15:8] : VS_NONE};
         8: return m[4][FLG_CSI_VAL] ? m[8] : 32'h0;
         9: return m[4][FLG_CSI_VAL] ? m[9] : 32'h0;
         default: return 32'h0;
      endcase
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic wrr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      m[ad[7:2]] = d;
   endtask

   task automatic rdr(input logic [7:0] ad, output logic [31:0] d);
      @(posedge clk);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic get(input logic [7:0] l, input logic [31:0] n, input logic [6:0] d,
                      input logic [1:0] s, input logic [31:0] e);
      host.fetch(l, n, d, a, r);
      chk(a, 1);
      chk(r.status, s);
      chk(r.data, e);
   endtask

   // warning condition b (5 = none), then pulse and held event word
   task automatic ev(input int b, input logic p, input logic [4:0] w);
      @(posedge clk);
      hin <= mk((b == 1) ? 16'h0190 : 16'h012C, (b == 0) ? 8'h0A : 8'h64,
                3'((b > 1 && b < 5) ? 1 << (4 - b) : 0));
      @(posedge clk);
      #1;
      chk(aen_pulse, p);
      chk(aen_warn, w);
   endtask

   task automatic stop_test();
      if (miscompares == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      #1_000_000;
      miscompares++;
      stop_test();
   end

   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      seed = 32'hffdc_60e8;
      hin = mk(16'h012C, 8'h64, 3'h0);
      m = '{default: 32'h0};
      m[2] = 32'h0000_FFFF;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk(lp_ack | aen_pulse, 0);
      rdr(R_TEMP_THR, x);
      chk(x, m[2]);
      rdr(8'h2C, x);
      chk(x, 32'h0);
      @(posedge clk);
      #1;
      chk(rdata, 32'h0);
      // three error entries: related, unrelated with low vendor id, random
      for (k = 0; k < 3; k++) begin
         for (i = 3; i < 10; i++) begin
            x = rnd();
            if (i == 4)
               x = (k == 0) ? (x | 32'h0000_8003) : (k == 1) ? 32'h0000_7F00 : x;
            wrr(8'(i * 4), x);
         end
         for (i = 0; i < 17; i++) begin
            if (i < 4)
               get(LID_ERR, rnd(), 7'(i), ST_OK, exp_err(i));
            else if (i < 7)
               get(LID_ERR, rnd(), 7'(i), ST_OK, exp_err(i));
            else if (i < 10)
               get(LID_ERR, rnd(), 7'(i), ST_OK, exp_err(i));
            else
               get(LID_ERR, rnd(), 7'(i), ST_OK, exp_err(i));
         end
      end
      for (i = 0; i < 4; i++)
         get(bad[i], NSID_GLOBAL, DW_H0, ST_BAD_LOG, 32'h0);
      wrr(R_SPARE_THR, 32'h0000_0014);
      wrr(R_TEMP_THR, 32'h010E_015E);
      for (j = 0; j < 8; j++) begin
         x = rnd();
         @(posedge clk);
         hin <= (j < 7) ? mk(tt[j], sp[j], fl[j]) : mk(x[15:0], x[23:16], x[26:24]);
         #1;
         get(LID_HLTH, NSID_GLOBAL, DW_H0, ST_OK, h0());
         get(LID_HLTH, NSID_GLOBAL, DW_H1, ST_OK, h1());
         rdr(R_WARN, x);
         chk(x, {27'h0, exp_warn()});
      end
      x = rnd() & 32'h7FFF_FFFF;
      get(LID_HLTH, x, DW_H0, ST_BAD_FIELD, 32'h0);
      wrr(R_CFG, 32'h0000_0001);
      get(LID_HLTH, x, DW_H0, ST_OK, h0());
      get(LID_HLTH, x, DW_H1, ST_OK, h1());
      hin <= mk(16'h012C, 8'h64, 3'h0);
      wrr(R_CFG, 32'h0000_1F00);
      for (j = 0; j < 5; j++) begin
         ev(j, 1, 5'(1 << j));
         ev(5, 0, 5'(1 << j));
      end
      wrr(R_CFG, 32'h0000_1700);
      ev(3, 0, 5'h10);
      ev(3, 0, 5'h10);
      stop_test();
   end
endmodule
